// ===== rtl/pbr_pkg.sv
/*
 * shared constants and types for the long-press reset timer.
 * assumes a single 50 MHz clock and a synchronous active-high reset.
 */
package pbr_pkg;

	// product variant, one-hot
	typedef enum logic [3:0]
	{
		PBR_VAR_LEVEL = 4'h1, // dual input, released by a button going high
		PBR_VAR_PULSE_SHORT = 4'h2, // dual input, short fixed pulse
		PBR_VAR_PULSE_LONG = 4'h4, // dual input, long fixed pulse
		PBR_VAR_SINGLE = 4'h8 // single input, long fixed pulse
	} pbr_variant_t;

	// controller states, one-hot
	typedef enum logic [3:0]
	{
		PBR_ST_IDLE = 4'h1, // low power, timer stopped
		PBR_ST_HOLD = 4'h2, // press being timed
		PBR_ST_ASSERT = 4'h4, // reset line pulled low
		PBR_ST_WAIT = 4'h8 // pulse done, waiting for release
	} pbr_state_t;

	localparam int PBR_CNT_W = 30;
	localparam int PBR_CLK_HZ = 50_000_000;
	localparam int PBR_CYC_PER_MS = PBR_CLK_HZ / 1000;

	// times as printed, in milliseconds
	localparam int PBR_HOLD_LONG_MS = 12500;
	localparam int PBR_HOLD_MID_MS = 7500;
	localparam int PBR_HOLD_ZERO_MS = 0;
	localparam int PBR_PULSE_SHORT_MS = 80;
	localparam int PBR_PULSE_LONG_MS = 400;

	// derived cycle counts
	localparam logic [PBR_CNT_W-1:0] PBR_HOLD_LONG_CYC =
		PBR_CNT_W'(PBR_HOLD_LONG_MS * PBR_CYC_PER_MS);
	localparam logic [PBR_CNT_W-1:0] PBR_HOLD_MID_CYC =
		PBR_CNT_W'(PBR_HOLD_MID_MS * PBR_CYC_PER_MS);
	localparam logic [PBR_CNT_W-1:0] PBR_HOLD_ZERO_CYC =
		PBR_CNT_W'(PBR_HOLD_ZERO_MS * PBR_CYC_PER_MS);
	localparam logic [PBR_CNT_W-1:0] PBR_PULSE_SHORT_CYC =
		PBR_CNT_W'(PBR_PULSE_SHORT_MS * PBR_CYC_PER_MS);
	localparam logic [PBR_CNT_W-1:0] PBR_PULSE_LONG_CYC =
		PBR_CNT_W'(PBR_PULSE_LONG_MS * PBR_CYC_PER_MS);

	// reset values
	localparam logic [PBR_CNT_W-1:0] PBR_CNT_RST = 30'h0000_0000;
	localparam logic PBR_PIN_IDLE = 1'h1; // released buttons read high

endpackage : pbr_pkg

// ===== rtl/pbr_sync.sv
/*
 * two-flop synchroniser for slow pins.
 * assumes inputs are asynchronous to sys_clk_in; reset value is a constant.
 */
module pbr_sync #(
	parameter int WIDTH = 1,
	parameter logic RST_VAL = 1'h1
) (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import pbr_pkg::*;

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// first stage is read only by the second
	always_comb
	begin
		nxt_meta = async_in;
		nxt_sync = meta_ff;
		if (srst_in)
		begin
			nxt_meta = {WIDTH{RST_VAL}};
			nxt_sync = {WIDTH{RST_VAL}};
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		meta_ff <= nxt_meta;
		sync_ff <= nxt_sync;
	end

	assign sync_out = sync_ff;

endmodule : pbr_sync

// ===== rtl/pbr_timer.sv
/*
 * long-press reset timer: one or two active-low buttons held for the
 * selected delay pull an open-drain reset line low.
 * assumes buttons and the strap are asynchronous pins, a pull-up on the
 * reset line outside, and that the strap is not moved during a press.
 */
module pbr_timer #(
	parameter pbr_pkg::pbr_variant_t VARIANT = pbr_pkg::PBR_VAR_LEVEL,
	parameter logic [pbr_pkg::PBR_CNT_W-1:0] HOLD_LONG_CYC = pbr_pkg::PBR_HOLD_LONG_CYC,
	parameter logic [pbr_pkg::PBR_CNT_W-1:0] HOLD_MID_CYC = pbr_pkg::PBR_HOLD_MID_CYC,
	parameter logic [pbr_pkg::PBR_CNT_W-1:0] HOLD_ZERO_CYC = pbr_pkg::PBR_HOLD_ZERO_CYC,
	parameter logic [pbr_pkg::PBR_CNT_W-1:0] PULSE_SHORT_CYC = pbr_pkg::PBR_PULSE_SHORT_CYC,
	parameter logic [pbr_pkg::PBR_CNT_W-1:0] PULSE_LONG_CYC = pbr_pkg::PBR_PULSE_LONG_CYC
) (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic button_in_a_n_in,
	input wire logic button_in_b_n_in,
	input wire logic delay_select_in,
	output logic reset_out_n_out,
	output logic reset_out_n_oe_out,
	output logic timer_active_out
);
	import pbr_pkg::*;

	localparam bit IS_LEVEL = (VARIANT == PBR_VAR_LEVEL);
	localparam bit IS_SINGLE = (VARIANT == PBR_VAR_SINGLE);

	// delay choice per variant and strap level
	function automatic logic [PBR_CNT_W-1:0] hold_for(input logic sel);
		logic [PBR_CNT_W-1:0] val;
		val = HOLD_MID_CYC;
		if (sel)
		begin
			val = IS_LEVEL ? HOLD_LONG_CYC : HOLD_ZERO_CYC;
		end
		return val;
	endfunction : hold_for

	localparam logic [PBR_CNT_W-1:0] PULSE_CYC =
		(VARIANT == PBR_VAR_PULSE_SHORT) ? PULSE_SHORT_CYC : PULSE_LONG_CYC;
	localparam logic [PBR_CNT_W-1:0] ONE = 30'h0000_0001;

	logic [2:0] pins_sync;
	logic btn_a_n;
	logic btn_b_n;
	logic sel_sync;
	logic pressed;

	pbr_state_t state_ff;
	pbr_state_t nxt_state;
	logic [PBR_CNT_W-1:0] cnt_ff;
	logic [PBR_CNT_W-1:0] nxt_cnt;
	logic [PBR_CNT_W-1:0] target_ff;
	logic [PBR_CNT_W-1:0] nxt_target;
	logic oe_ff;
	logic nxt_oe;
	logic pin_ff;
	logic nxt_pin;
	logic active_ff;
	logic nxt_active;

	// all pins are asynchronous; buttons idle high
	pbr_sync #(
		.WIDTH(3),
		.RST_VAL(PBR_PIN_IDLE)
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.async_in({delay_select_in, button_in_b_n_in, button_in_a_n_in}),
		.sync_out(pins_sync)
	);

	assign btn_a_n = pins_sync[0];
	assign btn_b_n = pins_sync[1];
	assign sel_sync = pins_sync[2];

	// single variant ignores the second button entirely
	assign pressed = IS_SINGLE ? !btn_a_n : (!btn_a_n && !btn_b_n);

	// press timing and pulse sequencing
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_target = target_ff;
		case (state_ff)
			PBR_ST_IDLE:
			begin
				nxt_cnt = PBR_CNT_RST;
				// strap read at press start; later moves are the system's fault
				nxt_target = hold_for(sel_sync);
				if (pressed)
				begin
					if (hold_for(sel_sync) == PBR_CNT_RST)
					begin
						nxt_state = PBR_ST_ASSERT; // zero delay
					end
					else if (hold_for(sel_sync) == ONE)
					begin
						nxt_state = PBR_ST_ASSERT;
					end
					else
					begin
						nxt_state = PBR_ST_HOLD;
						nxt_cnt = ONE;
					end
				end
			end
			PBR_ST_HOLD:
			begin
				if (!pressed)
				begin
					nxt_state = PBR_ST_IDLE; // abandon, restart from zero
					nxt_cnt = PBR_CNT_RST;
				end
				else if (cnt_ff == target_ff - ONE)
				begin
					nxt_state = PBR_ST_ASSERT;
					nxt_cnt = PBR_CNT_RST;
				end
				else
				begin
					nxt_cnt = cnt_ff + ONE;
				end
			end
			PBR_ST_ASSERT:
			begin
				if (IS_LEVEL)
				begin
					if (!pressed)
					begin
						nxt_state = PBR_ST_IDLE;
						nxt_cnt = PBR_CNT_RST;
					end
				end
				else if (cnt_ff == PULSE_CYC - ONE)
				begin
					nxt_state = PBR_ST_WAIT; // pulse done
					nxt_cnt = PBR_CNT_RST;
				end
				else
				begin
					nxt_cnt = cnt_ff + ONE; // pulse runs on even if released
				end
			end
			PBR_ST_WAIT:
			begin
				nxt_cnt = PBR_CNT_RST;
				if (!pressed)
				begin
					nxt_state = PBR_ST_IDLE; // need release before rearm
				end
			end
			default:
			begin
				nxt_state = PBR_ST_IDLE;
				nxt_cnt = PBR_CNT_RST;
			end
		endcase
		if (srst_in)
		begin
			nxt_state = PBR_ST_IDLE;
			nxt_cnt = PBR_CNT_RST;
			nxt_target = HOLD_MID_CYC;
		end
	end

	// output drivers follow the next state so the pin has no extra lag
	always_comb
	begin
		nxt_oe = (nxt_state == PBR_ST_ASSERT); // pull low only while asserting
		nxt_pin = 1'h0; // never drives high
		nxt_active = (nxt_state == PBR_ST_HOLD) || (nxt_state == PBR_ST_ASSERT);
		if (srst_in)
		begin
			nxt_oe = 1'h0;
			nxt_active = 1'h0;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		state_ff <= nxt_state;
		cnt_ff <= nxt_cnt;
		target_ff <= nxt_target;
		oe_ff <= nxt_oe;
		pin_ff <= nxt_pin;
		active_ff <= nxt_active;
	end

	assign reset_out_n_out = pin_ff;
	assign reset_out_n_oe_out = oe_ff;
	assign timer_active_out = active_ff;

	// checks
	a_oe_tracks_state: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		!reset_out_n_out && (reset_out_n_oe_out == (state_ff == PBR_ST_ASSERT)))
		else $error("reset line driven outside assert state");

	a_level_release: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(IS_LEVEL && reset_out_n_oe_out && !pressed) |=> !reset_out_n_oe_out)
		else $error("level variant held reset after a button went high");

	a_level_holds: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(IS_LEVEL && reset_out_n_oe_out && pressed) |=> reset_out_n_oe_out)
		else $error("level variant dropped reset while pressed");

	a_assert_cause: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		$rose(reset_out_n_oe_out) |-> $past(pressed) &&
		(($past(state_ff) == PBR_ST_HOLD && $past(cnt_ff) == $past(target_ff) - ONE) ||
		($past(state_ff) == PBR_ST_IDLE && $past(hold_for(sel_sync)) <= ONE)))
		else $error("reset asserted without a full hold");

	a_press_abandon: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_ff == PBR_ST_HOLD && !pressed) |=>
		(state_ff == PBR_ST_IDLE && cnt_ff == PBR_CNT_RST && !reset_out_n_oe_out))
		else $error("early release did not abandon the count");

	a_pulse_length: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(!IS_LEVEL && $fell(reset_out_n_oe_out)) |->
		($past(cnt_ff) == PULSE_CYC - ONE && state_ff == PBR_ST_WAIT))
		else $error("reset pulse ended at the wrong count");

	a_no_retrigger: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_ff == PBR_ST_WAIT && pressed) |=> !reset_out_n_oe_out)
		else $error("reset re-asserted before release");

	a_timer_idle: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(state_ff == PBR_ST_IDLE || state_ff == PBR_ST_WAIT) |->
		(cnt_ff == PBR_CNT_RST && !timer_active_out))
		else $error("timer running while idle");

	a_zero_delay: assert property (@(posedge sys_clk_in) disable iff (srst_in)
		(!IS_LEVEL && state_ff == PBR_ST_IDLE && pressed && sel_sync) |=> reset_out_n_oe_out)
		else $error("zero delay did not assert at once");

	c_full_hold: cover property (@(posedge sys_clk_in) disable iff (srst_in)
		state_ff == PBR_ST_HOLD ##1 state_ff == PBR_ST_ASSERT);
	c_abandon: cover property (@(posedge sys_clk_in) disable iff (srst_in)
		state_ff == PBR_ST_HOLD ##1 state_ff == PBR_ST_IDLE);
	c_pulse_done: cover property (@(posedge sys_clk_in) disable iff (srst_in)
		state_ff == PBR_ST_WAIT ##1 state_ff == PBR_ST_IDLE);

endmodule : pbr_timer

// ===== sim/pbr_btn_model.sv
/*
 * two mechanical push buttons and the pulled-up system reset line.
 * assumes every timer instance shares the buttons and the one line.
 */
module pbr_btn_model
(
	input wire logic press_a_in,
	input wire logic press_b_in,
	input wire logic [3:0] drv_n_in,
	input wire logic [3:0] oe_in,
	output logic button_a_n_out,
	output logic button_b_n_out,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// closed contact grounds the pin, open contact reads high by pull-up
	assign button_a_n_out = !press_a_in;
	assign button_b_n_out = !press_b_in;
	// wired line: any enabled driver driving low pulls it low, else the pull-up wins
	assign line_out = ((oe_in & ~drv_n_in) != 4'h0) ? 1'h0 : 1'h1;
endmodule : pbr_btn_model

// ===== sim/tb_pbr_timer.sv
/*
 * bench for the long-press reset timer, all four variants side by side.
 * assumes short hold and pulse counts set through the parameters.
 */
module tb_pbr_timer;
	timeunit 1ns;
	timeprecision 100ps;
	import pbr_pkg::*;
	localparam pbr_variant_t VARS [4] = '{PBR_VAR_LEVEL, PBR_VAR_PULSE_SHORT,
		PBR_VAR_PULSE_LONG, PBR_VAR_SINGLE};
	logic sys_clk_in = 1'h0;
	logic srst_in = 1'h1;
	logic sel = 1'h0;
	logic press_a = 1'h0;
	logic press_b = 1'h0;
	wire logic btn_a_n;
	wire logic btn_b_n;
	wire logic line;
	wire logic [3:0] oe;
	wire logic [3:0] drv_n;
	wire logic [3:0] act;
	int miscompares = 0;
	int checks_done = 0;
	int rise [4];
	int width [4];
	int actw [4];

	// one instance per variant, all sharing the same buttons and strap
	for (genvar g = 0; g < 4; g++)
	begin : g_dut
		pbr_timer #(.VARIANT(VARS[g]), .HOLD_LONG_CYC(30'h0000_000c),
			.HOLD_MID_CYC(30'h0000_0008), .HOLD_ZERO_CYC(30'h0000_0000),
			.PULSE_SHORT_CYC(30'h0000_0004), .PULSE_LONG_CYC(30'h0000_0006))
		pbr_timer_inst (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
			.button_in_a_n_in(btn_a_n), .button_in_b_n_in(btn_b_n),
			.delay_select_in(sel), .reset_out_n_out(drv_n[g]),
			.reset_out_n_oe_out(oe[g]), .timer_active_out(act[g]));
	end

	pbr_btn_model pbr_btn_model_inst (.press_a_in(press_a), .press_b_in(press_b),
		.drv_n_in(drv_n), .oe_in(oe), .button_a_n_out(btn_a_n),
		.button_b_n_out(btn_b_n), .line_out(line));

	always #10 sys_clk_in = !sys_clk_in;

	task chk(input string what, input int exp, input int got);
		checks_done++;
		if (exp != got)
		begin
			miscompares++;
			$display("BAD %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk

	task chk4(input string what, input int exp [4], input int got [4]);
		for (int k = 0; k < 4; k++)
			chk(what, exp[k], got[k]);
	endtask : chk4

	// press for n cycles, then 12 idle cycles; records first high and cycles high
	task run_press(input logic s, input logic a, input logic b, input int n);
		sel = s; // strap only moves while both buttons are released
		repeat (4) @(posedge sys_clk_in);
		#1;
		press_a = a;
		press_b = b;
		rise = '{default: 0};
		width = '{default: 0};
		actw = '{default: 0};
		for (int i = 1; i <= n + 12; i++)
		begin
			if (i == n + 1)
			begin
				press_a = 1'h0;
				press_b = 1'h0;
			end
			@(posedge sys_clk_in);
			#1;
			// active cycles cover both press timing and pulse, never the wait
			for (int k = 0; k < 4; k++)
			begin
				if (oe[k] === 1'h1)
				begin
					rise[k] = (rise[k] == 0) ? i : rise[k];
					width[k]++;
				end
				if (act[k] === 1'h1)
					actw[k]++;
			end
			if (oe !== 4'h0)
				chk("line pulled low", 1, int'(line === 1'h0));
			else
				chk("line released", 1, int'(line === 1'h1));
			chk("drive level", 1, int'(drv_n === 4'h0));
		end
		chk("all timers idle", 1, int'(act === 4'h0));
	endtask : run_press

	// zero delay on pulse variants, long delay on level variant
	task sc_strap_high;
		run_press(1'h1, 1'h1, 1'h1, 30);
		chk4("rise", '{14, 3, 3, 3}, rise);
		chk4("width", '{19, 4, 6, 6}, width);
		chk4("active", '{30, 4, 6, 6}, actw);
	endtask : sc_strap_high

	task sc_strap_low;
		run_press(1'h0, 1'h1, 1'h1, 20);
		chk4("rise", '{10, 10, 10, 10}, rise);
		chk4("width", '{13, 4, 6, 6}, width);
		chk4("active", '{20, 11, 13, 13}, actw);
	endtask : sc_strap_low

	// short press must leave no trace, a full press then times from zero
	task sc_abandon;
		run_press(1'h0, 1'h1, 1'h1, 6);
		chk4("rise", '{0, 0, 0, 0}, rise);
		run_press(1'h0, 1'h1, 1'h1, 20);
		chk4("rise", '{10, 10, 10, 10}, rise);
	endtask : sc_abandon

	// button a alone: only the single-input variant answers; button b alone: no variant answers
	task sc_single;
		run_press(1'h0, 1'h1, 1'h0, 20);
		chk4("rise", '{0, 0, 0, 10}, rise);
		chk4("width", '{0, 0, 0, 6}, width);
		run_press(1'h0, 1'h0, 1'h1, 20);
		chk4("rise", '{0, 0, 0, 0}, rise);
	endtask : sc_single

	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	initial
	begin
		repeat (5) @(posedge sys_clk_in);
		#1;
		srst_in = 1'h0;
		sc_strap_high();
		sc_strap_low();
		sc_abandon();
		sc_single();
		give_verdict();
	end

	// whole run is a few hundred cycles; this cuts a hang short
	initial
	begin
		repeat (5000) @(posedge sys_clk_in);
		miscompares++;
		give_verdict();
	end
endmodule : tb_pbr_timer
